// ===== design/cfg_check_pkg.sv
// constants and types for the network configuration check block
package cfg_check_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_MS = 2000;
  localparam int unsigned HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int unsigned CNT_W = 25;
  localparam int unsigned MAX_MOD = 16;
  localparam int unsigned ID_W = 8;
  localparam int unsigned IDX_W = 5;

  typedef enum logic [1:0] {
    col_off,
    col_red,
    col_green,
    col_orange
  } colour_e;

  typedef enum logic [2:0] {
    st_scan,
    st_addr,
    st_compare,
    st_capture,
    st_store,
    st_ready,
    st_fault
  } phase_e;
endpackage

// ===== design/fieldbus_config_check_status.sv
// configuration check, capture and LED indication of the network master port
`timescale 1ns/1ns
`default_nettype none
module fieldbus_config_check_status #(
  parameter int unsigned HOLD_CYCLES = cfg_check_pkg::HOLD_CYC,
  parameter int unsigned FLASH_CYCLES = cfg_check_pkg::FLASH_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic config_button_n,
  input wire logic supply_short,
  input wire logic supply_ok,
  input wire logic scan_done,
  input wire logic [cfg_check_pkg::IDX_W-1:0] found_count,
  input wire logic [cfg_check_pkg::ID_W-1:0] found_id,
  input wire logic required_missing,
  input wire logic addr_done,
  input wire logic [cfg_check_pkg::IDX_W-1:0] mod_index,
  input wire logic project_present,
  input wire logic [cfg_check_pkg::IDX_W-1:0] project_count,
  input wire logic [cfg_check_pkg::ID_W-1:0] project_id,
  input wire logic project_compatible,
  output logic scan_start,
  output logic addr_start,
  output logic select_out,
  output logic network_ready,
  output logic data_exchange_en,
  output logic store_we,
  output logic target_valid,
  output logic [1:0] network_status_led,
  output logic [1:0] project_match_led,
  output logic module_supply_led
);
  // button and supply sense come from pins: three-stage sync
  logic [2:0] btn_sync_r;
  logic [2:0] sup_sync_r;
  logic [2:0] pow_sync_r;
  logic btn_held_r, btn_held_nxt;
  logic sup_r, sup_nxt;
  logic pow_r, pow_nxt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      btn_sync_r <= 3'h0;
      sup_sync_r <= 3'h0;
      pow_sync_r <= 3'h7;
      btn_held_r <= 1'b0;
      sup_r <= 1'b0;
      pow_r <= 1'b1;
    end else begin
      btn_sync_r <= {btn_sync_r[1:0], ~config_button_n};
      sup_sync_r <= {sup_sync_r[1:0], supply_short};
      pow_sync_r <= {pow_sync_r[1:0], supply_ok};
      btn_held_r <= btn_held_nxt;
      sup_r <= sup_nxt;
      pow_r <= pow_nxt;
    end
  end
  always_comb begin
    btn_held_nxt = (btn_sync_r[1] == btn_sync_r[2]) ? btn_sync_r[2] : btn_held_r;
    sup_nxt = (sup_sync_r[1] == sup_sync_r[2]) ? sup_sync_r[2] : sup_r;
    pow_nxt = (pow_sync_r[1] == pow_sync_r[2]) ? pow_sync_r[2] : pow_r;
  end
  // network supply coming up counts as a power-up; idle high, so no edge after reset
  logic pow_up;
  assign pow_up = pow_nxt && !pow_r;

  // long-press detector
  logic [cfg_check_pkg::CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
  logic long_press_r, long_press_nxt;
  always_comb begin
    hold_cnt_nxt = hold_cnt_r;
    long_press_nxt = 1'b0;
    if (!btn_held_r) begin
      hold_cnt_nxt = '0;
    end else if (hold_cnt_r < HOLD_CYCLES[cfg_check_pkg::CNT_W-1:0] - 1'b1) begin
      hold_cnt_nxt = hold_cnt_r + 1'b1;
    end else if (hold_cnt_r == HOLD_CYCLES[cfg_check_pkg::CNT_W-1:0] - 1'b1) begin
      hold_cnt_nxt = hold_cnt_r + 1'b1;
      long_press_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt_r <= '0;
      long_press_r <= 1'b0;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      long_press_r <= long_press_nxt;
    end
  end

  // retentive target table, flip-flops addressed by module index
  logic [cfg_check_pkg::ID_W-1:0] target_r [cfg_check_pkg::MAX_MOD];
  logic [cfg_check_pkg::IDX_W-1:0] target_cnt_r;
  logic tvalid_r;

  cfg_check_pkg::phase_e phase_r, phase_nxt;
  logic [cfg_check_pkg::IDX_W-1:0] cnt_nxt;
  logic tvalid_nxt;
  logic mismatch_r, mismatch_nxt;
  logic none_r, none_nxt;
  logic capture_r, capture_nxt;
  logic scan_start_nxt, addr_start_nxt, we_nxt;
  logic [cfg_check_pkg::ID_W-1:0] cur_target;
  assign cur_target = target_r[mod_index[cfg_check_pkg::IDX_W-2:0]];

  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = target_cnt_r;
    tvalid_nxt = tvalid_r;
    mismatch_nxt = mismatch_r;
    none_nxt = none_r;
    capture_nxt = capture_r;
    scan_start_nxt = 1'b0;
    addr_start_nxt = 1'b0;
    we_nxt = 1'b0;
    unique case (phase_r)
      cfg_check_pkg::st_scan: begin
        if (scan_done) begin
          none_nxt = (found_count == '0);
          if (found_count == '0) begin
            phase_nxt = cfg_check_pkg::st_fault;
          end else begin
            addr_start_nxt = 1'b1;
            phase_nxt = cfg_check_pkg::st_addr;
          end
        end
      end
      cfg_check_pkg::st_addr: begin
        if (addr_done) begin
          mismatch_nxt = capture_r ? 1'b0 : (found_count != target_cnt_r);
          phase_nxt = capture_r ? cfg_check_pkg::st_store : cfg_check_pkg::st_compare;
        end
      end
      cfg_check_pkg::st_compare: begin
        if (mod_index < found_count) begin
          if (found_id != cur_target) begin
            mismatch_nxt = 1'b1;
          end
        end else begin
          phase_nxt = (mismatch_r || required_missing || !tvalid_r) ?
                      cfg_check_pkg::st_fault : cfg_check_pkg::st_ready;
        end
      end
      cfg_check_pkg::st_capture: begin
        scan_start_nxt = 1'b1;
        phase_nxt = cfg_check_pkg::st_scan;
      end
      cfg_check_pkg::st_store: begin
        if (mod_index < found_count) begin
          we_nxt = 1'b1;
        end else begin
          cnt_nxt = found_count;
          tvalid_nxt = 1'b1;
          capture_nxt = 1'b0;
          mismatch_nxt = 1'b0;
          phase_nxt = cfg_check_pkg::st_ready;
        end
      end
      cfg_check_pkg::st_ready, cfg_check_pkg::st_fault: begin
        phase_nxt = phase_r;
      end
      default: begin
        phase_nxt = cfg_check_pkg::st_scan;
      end
    endcase
    if (pow_up && (phase_r == cfg_check_pkg::st_ready || phase_r == cfg_check_pkg::st_fault)) begin
      mismatch_nxt = 1'b0;
      none_nxt = 1'b0;
      phase_nxt = cfg_check_pkg::st_capture;
    end
    if (long_press_r && phase_r != cfg_check_pkg::st_scan &&
        phase_r != cfg_check_pkg::st_addr && phase_r != cfg_check_pkg::st_store) begin
      capture_nxt = 1'b1;
      phase_nxt = cfg_check_pkg::st_capture;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r <= cfg_check_pkg::st_capture;
      capture_r <= 1'b0;
      target_cnt_r <= '0;
      tvalid_r <= 1'b0;
      mismatch_r <= 1'b0;
      none_r <= 1'b0;
      scan_start <= 1'b0;
      addr_start <= 1'b0;
      store_we <= 1'b0;
    end else begin
      phase_r <= (phase_r == cfg_check_pkg::st_capture && !capture_r && !long_press_r) ?
                 cfg_check_pkg::st_scan : phase_nxt;
      capture_r <= capture_nxt;
      target_cnt_r <= cnt_nxt;
      tvalid_r <= tvalid_nxt;
      mismatch_r <= mismatch_nxt;
      none_r <= none_nxt;
      scan_start <= scan_start_nxt || (phase_r == cfg_check_pkg::st_capture);
      addr_start <= addr_start_nxt;
      store_we <= we_nxt;
    end
  end
  always_ff @(posedge core_clk) begin
    if (we_nxt) begin
      target_r[mod_index[cfg_check_pkg::IDX_W-2:0]] <= found_id;
    end
  end

  // project comparison against stored target
  // verdict latched once per index walk, so one differing module cannot flicker it
  logic proj_acc_r, proj_acc_nxt;
  logic proj_same_r, proj_same_nxt;
  always_comb begin
    proj_acc_nxt = proj_acc_r;
    proj_same_nxt = proj_same_r;
    if (mod_index < target_cnt_r) begin
      proj_acc_nxt = proj_acc_r || (project_id != cur_target);
    end else begin
      proj_acc_nxt = 1'b0;
      proj_same_nxt = project_present && (project_count == target_cnt_r) && !proj_acc_r;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      proj_acc_r <= 1'b0;
      proj_same_r <= 1'b0;
    end else begin
      proj_acc_r <= proj_acc_nxt;
      proj_same_r <= proj_same_nxt;
    end
  end

  logic [cfg_check_pkg::CNT_W-1:0] flash_cnt_r, flash_cnt_nxt;
  logic phase_on_r, phase_on_nxt;
  always_comb begin
    flash_cnt_nxt = flash_cnt_r + 1'b1;
    phase_on_nxt = phase_on_r;
    if (flash_cnt_r == FLASH_CYCLES[cfg_check_pkg::CNT_W-1:0] - 1'b1) begin
      flash_cnt_nxt = '0;
      phase_on_nxt = ~phase_on_r;
    end
  end

  cfg_check_pkg::colour_e net_col, prj_col;
  logic net_flash, prj_flash;
  logic ready_now;
  assign ready_now = (phase_r == cfg_check_pkg::st_ready);
  always_comb begin
    net_col = cfg_check_pkg::col_off;
    net_flash = 1'b0;
    if (sup_r || (phase_r == cfg_check_pkg::st_fault && none_r)) begin
      net_col = cfg_check_pkg::col_red;
    end else if (capture_r) begin
      net_col = cfg_check_pkg::col_orange;
      net_flash = 1'b1;
    end else if (!tvalid_r) begin
      net_col = cfg_check_pkg::col_off;
    end else if (phase_r == cfg_check_pkg::st_fault) begin
      net_col = cfg_check_pkg::col_red;
      net_flash = 1'b1;
    end else if (ready_now) begin
      net_col = cfg_check_pkg::col_green;
    end else begin
      net_col = cfg_check_pkg::col_green;
      net_flash = 1'b1;
    end
    prj_col = cfg_check_pkg::col_off;
    prj_flash = 1'b0;
    if (!project_present || !ready_now) begin
      prj_col = cfg_check_pkg::col_off;
    end else if (proj_same_r) begin
      prj_col = cfg_check_pkg::col_green;
    end else if (project_compatible) begin
      prj_col = cfg_check_pkg::col_green;
      prj_flash = 1'b1;
    end else begin
      prj_col = cfg_check_pkg::col_red;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_cnt_r <= '0;
      phase_on_r <= 1'b0;
      network_status_led <= 2'h0;
      project_match_led <= 2'h0;
      module_supply_led <= 1'b0;
      network_ready <= 1'b0;
      data_exchange_en <= 1'b0;
      target_valid <= 1'b0;
      select_out <= 1'b0;
    end else begin
      flash_cnt_r <= flash_cnt_nxt;
      phase_on_r <= phase_on_nxt;
      network_status_led <= (net_flash && !phase_on_r) ? 2'h0 : net_col;
      project_match_led <= (prj_flash && !phase_on_r) ? 2'h0 : prj_col;
      module_supply_led <= pow_r && !sup_r;
      network_ready <= ready_now;
      data_exchange_en <= ready_now && project_present && proj_same_r;
      target_valid <= tvalid_r;
      select_out <= (phase_r == cfg_check_pkg::st_addr);
    end
  end
endmodule // fieldbus_config_check_status
`default_nettype wire

// ===== verification/cfg_status_checker.sv
// assertion checker for the configuration check block
`timescale 1ns/1ns
`default_nettype none
module cfg_status_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_short,
  input wire logic project_present,
  input wire logic scan_start,
  input wire logic addr_start,
  input wire logic select_out,
  input wire logic network_ready,
  input wire logic data_exchange_en,
  input wire logic store_we,
  input wire logic target_valid,
  input wire logic [1:0] network_status_led,
  input wire logic [1:0] project_match_led
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_RST_DARK: assert property (disable iff (1'b0) rst |=> network_status_led == 2'h0)
    else $error("status led lit after reset");
  AST_SCAN_PULSE: assert property (scan_start |=> !scan_start)
    else $error("scan_start too long");
  AST_READY_TARGET: assert property (network_ready |-> target_valid)
    else $error("ready without target");
  AST_DX_READY: assert property (data_exchange_en |-> network_ready && project_present)
    else $error("exchange too early");
  AST_DX_GREEN: assert property (data_exchange_en [*2] |-> project_match_led == 2'h2)
    else $error("exchange without green");
  AST_SHORT_RED: assert property (supply_short [*6] |-> network_status_led == 2'h1)
    else $error("short not red");
  AST_STORE_ORANGE: assert property (store_we |-> network_status_led inside {2'h0, 2'h3})
    else $error("store not orange");
  AST_ADDR_SELECT: assert property (addr_start |-> ##[0:1] select_out)
    else $error("no select in addressing");
  cover property (store_we);
  cover property (data_exchange_en);
  cover property (supply_short [*6]);
endmodule // cfg_status_checker
`default_nettype wire

// ===== verification/slave_chain_model.sv
// behavioural chain of slave modules on the network
`timescale 1ns/1ns
`default_nettype none
module slave_chain_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scan_start,
  input wire logic addr_start,
  input wire logic select_out,
  input wire logic [4:0] found_count,
  input wire logic [7:0] id_base,
  output logic scan_done,
  output logic addr_done,
  output logic [4:0] mod_index,
  output logic [7:0] found_id
);
  logic [3:0] dly;
  logic sb, ab, walk;
  // id follows index, inverted off the walk
  assign found_id = (mod_index < found_count) ? id_base + 8'(mod_index) : ~id_base;
  always @(posedge core_clk) begin
    dly <= (scan_start || addr_start) ? 4'h0 : dly + 4'h1;
    sb <= !rst && (scan_start || (sb && dly != 4'h5));
    scan_done <= !rst && sb && dly == 4'h5;
    ab <= !rst && (addr_start || (ab && !addr_done));
    addr_done <= !rst && ab && select_out && dly == 4'h5;
    walk <= !rst && (walk || addr_done);
    // every addressing run restarts the walk at the first module
    mod_index <= (!walk || addr_done || mod_index >= found_count) ? 5'h0 : mod_index + 5'h1;
  end
endmodule // slave_chain_model
`default_nettype wire

// ===== verification/fieldbus_config_check_status_tb_top.sv
// self-checking bench for the configuration check block
`timescale 1ns/1ns
`default_nettype none
module fieldbus_config_check_status_tb_top;
  logic core_clk = 1'b0, rst = 1'b1, config_button_n = 1'b1, supply_short = 1'b0;
  logic supply_ok = 1'b1, required_missing = 1'b0, project_present = 1'b0;
  logic project_compatible = 1'b0, seen_or = 1'b0, seen_gr = 1'b0;
  logic [4:0] found_count = 5'h3, project_count = 5'h3, mod_index;
  logic [7:0] id_base = 8'h20, pofs = 8'h00, found_id, project_id;
  logic scan_start, addr_start, select_out, network_ready, data_exchange_en, store_we;
  logic target_valid, module_supply_led, scan_done, addr_done;
  logic [1:0] network_status_led, project_match_led;
  logic [3:0] ms, mp;
  int error_cnt = 0, tests_run = 0, n_scan = 0, n_store = 0;
  assign project_id = id_base + pofs + 8'(mod_index);
  fieldbus_config_check_status #(.HOLD_CYCLES(20), .FLASH_CYCLES(4)) i_dut (.*);
  slave_chain_model i_chain (.*);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (scan_start === 1'b1) n_scan++;
    if (store_we === 1'b1) n_store++;
    if (network_status_led === 2'h3) seen_or = 1'b1;
    if (select_out === 1'b1 && network_status_led === 2'h2) seen_gr = 1'b1;
  end
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // colours seen on both leds over several flash periods
  task automatic led_mask();
    repeat (30) @(posedge core_clk);
    {ms, mp} = 8'h00;
    repeat (24) @(negedge core_clk) begin
      ms[network_status_led] = 1'b1;
      mp[project_match_led] = 1'b1;
    end
  endtask
  task automatic press(input int n);
    @(posedge core_clk) config_button_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    config_button_n <= 1'b1;
    led_mask();
  endtask
  task automatic proj(input logic c, input logic [7:0] o);
    @(posedge core_clk) project_present <= 1'b1;
    project_compatible <= c;
    pofs <= o;
    led_mask();
  endtask
  // network power cycle with a new module set
  task automatic pcycle(input logic [7:0] b, input logic m);
    @(posedge core_clk) supply_ok <= 1'b0;
    id_base <= b;
    required_missing <= m;
    repeat (10) @(posedge core_clk);
    supply_ok <= 1'b1;
    led_mask();
  endtask
  task automatic test_done();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    led_mask();
    chk("scan_start", 4'h1, 4'(n_scan));
    chk("status idle", 4'h1, ms);
    press(10);
    chk("target_valid", 4'h0, {3'h0, target_valid});
    press(30);
    for (int i = 0; i < 500 && network_ready !== 1'b1; i++) @(posedge core_clk);
    chk("network_ready", 4'h1, {3'h0, network_ready});
    chk("store_we", 4'h3, 4'(n_store));
    chk("orange seen", 4'h1, {3'h0, seen_or});
    led_mask();
    chk("status ready", 4'h4, ms);
    chk("match none", 4'h1, mp);
    proj(1'b1, 8'h00);
    chk("match equal", 4'h4, mp);
    chk("exchange on", 4'h1, {3'h0, data_exchange_en});
    proj(1'b1, 8'h01);
    chk("match compat", 4'h5, mp);
    chk("exchange off", 4'h0, {3'h0, data_exchange_en});
    proj(1'b0, 8'h01);
    chk("match incompat", 4'h2, mp);
    @(posedge core_clk) supply_short <= 1'b1;
    led_mask();
    chk("status short", 4'h2, ms);
    chk("supply led short", 4'h0, {3'h0, module_supply_led});
    @(posedge core_clk) supply_short <= 1'b0;
    supply_ok <= 1'b0;
    led_mask();
    chk("supply led off", 4'h0, {3'h0, module_supply_led});
    pcycle(8'h30, 1'b0);
    chk("status mismatch", 4'h3, ms);
    chk("ready mismatch", 4'h0, {3'h0, network_ready});
    chk("exchange mismatch", 4'h0, {3'h0, data_exchange_en});
    chk("green in addressing", 4'h1, {3'h0, seen_gr});
    pcycle(8'h20, 1'b1);
    chk("status required", 4'h3, ms);
    pcycle(8'h20, 1'b0);
    chk("status rematch", 4'h4, ms);
    chk("ready rematch", 4'h1, {3'h0, network_ready});
    chk("supply led on", 4'h1, {3'h0, module_supply_led});
    test_done();
  end
endmodule // fieldbus_config_check_status_tb_top
bind fieldbus_config_check_status cfg_status_checker i_chk (.*);
`default_nettype wire
